// ### rtl/urb_pkg.sv
// Constants and types shared by the upstream ranging and back-off block.
// Assumes one 200 MHz clock; map parsing is done upstream of this block.
package urb_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_MHZ        = 200;    // Core clock rate
	localparam int unsigned TICK_NS_X100   = 625000; // Tick, ns times 100
	// Cycles per timestamp tick, rounded down to whole cycles
	localparam int unsigned TICK_CYCLES    =
		(TICK_NS_X100 * CLK_MHZ) / 100000;
	localparam int unsigned SUBTICKS       = 64;     // Ticks per slot unit
	localparam int unsigned SUBTICK_LOG2   = 6;      // log2 of SUBTICKS
	localparam int unsigned LOST_SYNC_MS   = 600;    // Lost timing interval

	// ==========================================================
	// Protocol values
	// ==========================================================
	localparam logic [13:0] SID_UNINIT     = 14'h0000; // Unranged modem id
	localparam logic [4:0]  MAX_RETRIES    = 5'h10;    // Retry limit 16
	localparam logic [15:0] LFSR_RESET     = 16'hace1; // Nonzero start value
	localparam logic [31:0] TS_RESET       = 32'h0000_0000;

	// ==========================================================
	// Ranging state machine
	// ==========================================================
	typedef enum logic [5:0] {
		RS_IDLE   = 6'b000001, // Waiting for sync and channel descriptor
		RS_SEARCH = 6'b000010, // Scanning maps for initial maintenance
		RS_WRESP  = 6'b000100, // Request sent, waiting for response
		RS_WSTA   = 6'b001000, // Waiting for station maintenance slot
		RS_DONE   = 6'b010000, // Ranged, data traffic allowed
		RS_ABORT  = 6'b100000  // Head-end aborted ranging
	} urb_rng_type;

	// ==========================================================
	// Contention state machine
	// ==========================================================
	typedef enum logic [3:0] {
		CS_IDLE  = 4'b0001, // Nothing to send
		CS_DEFER = 4'b0010, // Skipping eligible opportunities
		CS_WACK  = 4'b0100, // Transmitted, waiting for acknowledgement
		CS_DRAW  = 4'b1000  // Drawing a new count after a loss
	} urb_cnt_type;

endpackage : urb_pkg

// ### rtl/urb_backoff.sv
// Truncated binary exponential back-off for one service identifier.
// Assumes map events arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
module urb_backoff (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Requests and map events
	input  wire logic        i_start,     // Data waiting, begin contention
	input  wire logic [3:0]  i_bo_start,  // Data back-off start exponent
	input  wire logic [3:0]  i_bo_end,    // Data back-off end exponent
	input  wire logic        i_opp,       // Eligible contention opportunity
	input  wire logic        i_dedicated, // Unicast request or data grant
	input  wire logic        i_ack,       // Grant, pending or acknowledge
	input  wire logic        i_map_late,  // Map without ack, ack time later
	input  wire logic        i_map_lost,  // Map lost or damaged
	input  wire logic        i_seed_ld,   // Load a new generator seed
	input  wire logic [15:0] i_seed,      // Seed, unique per modem
	// Results
	output logic             o_tx,        // Transmit in this opportunity
	output logic             o_done,      // Contention ended successfully
	output logic             o_discard,   // Retries used up, drop the unit
	output logic             o_busy       // Contention in progress
);
	import urb_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	urb_cnt_type st_q, st_d;     // Contention phase
	logic [3:0]  exp_q, exp_d;   // Current window exponent
	logic [15:0] cnt_q, cnt_d;   // Opportunities left to skip
	logic [4:0]  rty_q, rty_d;   // Retries so far
	logic [15:0] lfsr_q, lfsr_d; // Pseudo-random source
	logic        tx_q, tx_d;
	logic        dn_q, dn_d;
	logic        ds_q, ds_d;

	// Mask a random word down to the window 0 .. 2^k - 1
	function automatic logic [15:0] win_draw(input logic [15:0] r,
		input logic [3:0] k);
		win_draw = r & ((16'h0001 << k) - 16'h0001);
	endfunction : win_draw

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		st_d   = st_q;
		exp_d  = exp_q;
		cnt_d  = cnt_q;
		rty_d  = rty_q;
		tx_d   = 1'b0;
		dn_d   = 1'b0;
		ds_d   = 1'b0;
		// Free-running generator; reseed keeps modems apart
		lfsr_d = {lfsr_q[14:0],
			lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		if (i_seed_ld && i_seed != 16'h0000) begin
			lfsr_d = i_seed;
		end
		case (st_q)
			CS_IDLE: begin
				if (i_start) begin
					exp_d = i_bo_start;
					cnt_d = win_draw(lfsr_q, i_bo_start);
					rty_d = 5'h00;
					st_d  = CS_DEFER;
				end
			end
			CS_DEFER: begin
				if (i_dedicated) begin
					// Dedicated slot wins over contention
					dn_d = 1'b1;
					st_d = CS_IDLE;
				end else if (i_opp) begin
					// Only eligible opportunities reach here
					if (cnt_q == 16'h0000) begin
						tx_d = 1'b1;
						st_d = CS_WACK;
					end else begin
						cnt_d = cnt_q - 16'h0001;
					end
				end
			end
			CS_WACK: begin
				if (i_ack || i_map_lost || i_dedicated) begin
					// A lost map is taken as success
					dn_d = 1'b1;
					st_d = CS_IDLE;
				end else if (i_map_late) begin
					if (rty_q == MAX_RETRIES - 5'h01) begin
						ds_d = 1'b1;
						st_d = CS_IDLE;
					end else begin
						rty_d = rty_q + 5'h01;
						// Double unless already at the maximum
						if (exp_q < i_bo_end) begin
							exp_d = exp_q + 4'h1;
						end
						st_d = CS_DRAW;
					end
				end
			end
			CS_DRAW: begin
				cnt_d = win_draw(lfsr_q, exp_q);
				st_d  = CS_DEFER;
			end
			default: st_d = CS_IDLE;
		endcase
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q   <= CS_IDLE;
			exp_q  <= 4'h0;
			cnt_q  <= 16'h0000;
			rty_q  <= 5'h00;
			lfsr_q <= LFSR_RESET;
			tx_q   <= 1'b0;
			dn_q   <= 1'b0;
			ds_q   <= 1'b0;
		end else begin
			st_q   <= st_d;
			exp_q  <= exp_d;
			cnt_q  <= cnt_d;
			rty_q  <= rty_d;
			lfsr_q <= lfsr_d;
			tx_q   <= tx_d;
			dn_q   <= dn_d;
			ds_q   <= ds_d;
		end
	end

	assign o_tx      = tx_q;
	assign o_done    = dn_q;
	assign o_discard = ds_q;
	assign o_busy    = (st_q != CS_IDLE);

	// ==========================================================
	// Checks
	// ==========================================================
	a_start_window: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_q == CS_IDLE && i_start) |=> exp_q == $past(i_bo_start))
		else $error("window exponent not loaded from start value");
	a_window_cap: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_q == CS_WACK && i_map_late && !i_ack && !i_map_lost
		&& !i_dedicated && exp_q >= i_bo_end) |=> $stable(exp_q))
		else $error("window grew beyond maximum");
	a_retry_limit: assert property (@(posedge i_clk) disable iff (!i_resetn)
		rty_q < MAX_RETRIES)
		else $error("retry count passed limit");
	a_lost_map_ok: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_q == CS_WACK && i_map_lost) |=> o_done && !o_tx)
		else $error("lost map not treated as success");
	a_grant_abort: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_q == CS_DEFER && i_dedicated) |=> o_done && !o_busy)
		else $error("dedicated slot did not end contention");

endmodule : urb_backoff

// ### rtl/urb_top.sv
// Upstream ranging, timestamp to mini-slot mapping and contention back-off.
// Assumes map, timestamp and ranging response parsing happen elsewhere;
// their results arrive as synchronous pulses and levels on this clock.
//
// Operation
// - Search maps for initial maintenance after sync
// - Initial ranging request uses identifier zero
// - Offset starts at fixed internal delay
// - Then range in own station maintenance slot
// - Repeat until success or abort, then data
// - Timestamp counts fixed 6.25 us ticks
// - Ticks per mini-slot are a power of two
// - Mini-slot counter is 32 bits, wraps
// - Slot low bits equal timestamp high bits
// - Slot N starts at N times T times 64
// - Upper mini-slot bits may be ignored
// - Back-off values are window exponents
// - Start window from current map start value
// - Skip random count, send in next one
// - Count only eligible request opportunities
// - Missing acknowledgement in later map means loss
// - On loss double window up to maximum
// - Lost map while waiting counts as success
// - Discard after fifteen retries (sixteenth loss)
// - Dedicated slot or grant ends contention
// - Lost timing stops upstream and resyncs
`timescale 1ns/1ps
module urb_top #(
	parameter int unsigned LOST_CYCLES =
		urb_pkg::LOST_SYNC_MS * urb_pkg::CLK_MHZ * 1000,
	parameter logic [31:0] FIXED_DELAY = 32'h0000_0100 // Internal delay
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Downstream status
	input  wire logic        i_ds_sync,      // Downstream locked
	input  wire logic        i_ucd_valid,    // Channel descriptor held
	input  wire logic        i_sync_msg,     // Valid timestamp message
	input  wire logic [31:0] i_sync_ts,      // Timestamp carried
	input  wire logic [2:0]  i_ucd_m,        // log2 of 64-tick units per mini-slot
	// Map events
	input  wire logic        i_init_maint,   // Initial maintenance slot
	input  wire logic        i_sta_maint,    // Station slot for own id
	input  wire logic [3:0]  i_bo_start,     // Back-off start exponent
	input  wire logic [3:0]  i_bo_end,       // Back-off end exponent
	input  wire logic        i_cont_opp,     // Eligible contention opp
	input  wire logic        i_dedicated,    // Unicast request or grant
	input  wire logic        i_ack,          // Grant, pending or ack
	input  wire logic        i_map_late,     // Map lacks ack, later ack time
	input  wire logic        i_map_lost,     // Map lost or damaged
	// Ranging responses
	input  wire logic        i_rsp_valid,    // Ranging response arrived
	input  wire logic [13:0] i_rsp_sid,      // Temporary identifier
	input  wire logic [31:0] i_rsp_toff,     // Timing offset correction
	input  wire logic        i_rsp_success,  // Ranging successful
	input  wire logic        i_rsp_abort,    // Head-end aborted
	// Data path requests
	input  wire logic        i_pdu_ready,    // Data unit waiting
	input  wire logic        i_seed_ld,      // Load generator seed
	input  wire logic [15:0] i_seed,         // Seed value
	// Outputs
	output logic             o_rng_req,      // Send ranging request now
	output logic [13:0]      o_rng_sid,      // Identifier in the request
	output logic [31:0]      o_timing_off,   // Current timing offset
	output logic             o_ranged,       // Data traffic allowed
	output logic             o_up_enable,    // Upstream use allowed
	output logic             o_resync,       // Restart downstream sync
	output logic [31:0]      o_timestamp,    // Local timestamp counter
	output logic [31:0]      o_minislot,     // Mini-slot number
	output logic             o_slot_start,   // Mini-slot boundary pulse
	output logic             o_cont_tx,      // Contention transmit pulse
	output logic             o_cont_done,    // Contention ended
	output logic             o_cont_discard  // Data unit dropped
);
	import urb_pkg::*;

	// ==========================================================
	// Tick divider, timestamp and mini-slot counter
	// ==========================================================
	// Wide enough for a whole tick of cycles, so the rate stays exact
	logic [10:0] div_q, div_d;      // Cycles within one tick
	logic        tick;              // One tick enable pulse
	logic [31:0] ts_q, ts_d;        // Timestamp counter
	logic [31:0] ms_q, ms_d;        // Mini-slot counter
	logic        ss_q, ss_d;        // Mini-slot start pulse
	logic [31:0] ts_mask;           // Low timestamp bits inside one slot

	assign tick = (div_q == 11'(TICK_CYCLES - 1));
	// Bits below 6+M are zero exactly at a slot boundary
	assign ts_mask = (32'h0000_0040 << i_ucd_m) - 32'h0000_0001;

	// Timestamp counts ticks; a sync message realigns it
	always_comb begin
		div_d = tick ? 11'h000 : div_q + 11'h001;
		ts_d  = ts_q;
		ms_d  = ms_q;
		ss_d  = 1'b0;
		if (i_sync_msg) begin
			ts_d  = i_sync_ts;
			div_d = 11'h000;
			// Slot number follows the timestamp's high bits
			ms_d  = i_sync_ts >> (SUBTICK_LOG2 + 32'(i_ucd_m));
		end else if (tick) begin
			ts_d = ts_q + 32'h0000_0001;
			// New slot when ts equals N*T*64
			if ((ts_d & ts_mask) == 32'h0000_0000) begin
				ms_d = ms_q + 32'h0000_0001;
				ss_d = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			div_q <= 11'h000;
			ts_q  <= TS_RESET;
			ms_q  <= TS_RESET;
			ss_q  <= 1'b0;
		end else begin
			div_q <= div_d;
			ts_q  <= ts_d;
			ms_q  <= ms_d;
			ss_q  <= ss_d;
		end
	end

	// ==========================================================
	// Lost timing watchdog
	// ==========================================================
	// A long count, kept as a parameter so simulation can shorten it
	logic [31:0] lost_q, lost_d;    // Cycles since last sync message
	logic        rs_q, rs_d;        // Resync request level

	always_comb begin
		lost_d = lost_q;
		rs_d   = rs_q;
		if (i_sync_msg) begin
			lost_d = 32'h0000_0000;
			rs_d   = 1'b0;
		end else if (lost_q >= LOST_CYCLES - 1) begin
			rs_d = 1'b1;
		end else if (i_ds_sync) begin
			lost_d = lost_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lost_q <= 32'h0000_0000;
			rs_q   <= 1'b0;
		end else begin
			lost_q <= lost_d;
			rs_q   <= rs_d;
		end
	end

	// ==========================================================
	// Ranging sequence
	// ==========================================================
	urb_rng_type rng_q, rng_d;      // Ranging phase
	logic [31:0] toff_q, toff_d;    // Timing offset
	logic [13:0] sid_q, sid_d;      // Identifier used in requests
	logic        req_q, req_d;      // Request pulse
	logic        sync_ok;           // Upstream may be used at all

	// Upstream needs lock, a channel descriptor and live timing
	assign sync_ok = i_ds_sync && i_ucd_valid && !rs_q;

	always_comb begin
		rng_d  = rng_q;
		toff_d = toff_q;
		sid_d  = sid_q;
		req_d  = 1'b0;
		if (!sync_ok) begin
			// Loss of timing drops all upstream use
			rng_d  = RS_IDLE;
			toff_d = FIXED_DELAY;
			sid_d  = SID_UNINIT;
		end else begin
			case (rng_q)
				RS_IDLE: begin
					toff_d = FIXED_DELAY;
					sid_d  = SID_UNINIT;
					rng_d  = RS_SEARCH;
				end
				RS_SEARCH: begin
					if (i_init_maint) begin
						req_d = 1'b1;
						rng_d = RS_WRESP;
					end
				end
				RS_WRESP: begin
					if (i_rsp_valid) begin
						// Response carries id and corrections
						sid_d  = i_rsp_sid;
						toff_d = toff_q + i_rsp_toff;
						if (i_rsp_abort) begin
							rng_d = RS_ABORT;
						end else if (i_rsp_success) begin
							rng_d = RS_DONE;
						end else begin
							rng_d = RS_WSTA;
						end
					end
				end
				RS_WSTA: begin
					if (i_sta_maint) begin
						req_d = 1'b1;
						rng_d = RS_WRESP;
					end
				end
				RS_DONE:  rng_d = RS_DONE;
				RS_ABORT: rng_d = RS_ABORT;
				default:  rng_d = RS_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rng_q  <= RS_IDLE;
			toff_q <= 32'h0000_0000;
			sid_q  <= SID_UNINIT;
			req_q  <= 1'b0;
		end else begin
			rng_q  <= rng_d;
			toff_q <= toff_d;
			sid_q  <= sid_d;
			req_q  <= req_d;
		end
	end

	// ==========================================================
	// Contention back-off
	// ==========================================================
	logic bo_tx, bo_done, bo_disc;  // Back-off results
	logic bo_start;                 // Begin contention when ranged

	assign bo_start = i_pdu_ready && (rng_q == RS_DONE) && sync_ok;

	urb_backoff u_backoff (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_start     (bo_start),
		.i_bo_start  (i_bo_start),
		.i_bo_end    (i_bo_end),
		.i_opp       (i_cont_opp),
		.i_dedicated (i_dedicated),
		.i_ack       (i_ack),
		.i_map_late  (i_map_late),
		.i_map_lost  (i_map_lost),
		.i_seed_ld   (i_seed_ld),
		.i_seed      (i_seed),
		.o_tx        (bo_tx),
		.o_done      (bo_done),
		.o_discard   (bo_disc),
		.o_busy      ()
	);

	// ==========================================================
	// Output registers
	// ==========================================================
	logic up_q, rd_q, ctx_q, cdn_q, cds_q, rsy_q;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			up_q  <= 1'b0;
			rd_q  <= 1'b0;
			ctx_q <= 1'b0;
			cdn_q <= 1'b0;
			cds_q <= 1'b0;
			rsy_q <= 1'b0;
		end else begin
			up_q  <= sync_ok && rng_q != RS_ABORT;
			rd_q  <= sync_ok && rng_q == RS_DONE;
			ctx_q <= bo_tx && sync_ok;
			cdn_q <= bo_done;
			cds_q <= bo_disc;
			rsy_q <= rs_q;
		end
	end

	assign o_rng_req      = req_q;
	assign o_rng_sid      = sid_q;
	assign o_timing_off   = toff_q;
	assign o_ranged       = rd_q;
	assign o_up_enable    = up_q;
	assign o_resync       = rsy_q;
	assign o_timestamp    = ts_q;
	// Upper slot bits are kept, though alignment needs none
	assign o_minislot     = ms_q;
	assign o_slot_start   = ss_q;
	assign o_cont_tx      = ctx_q;
	assign o_cont_done    = cdn_q;
	assign o_cont_discard = cds_q;

	// ==========================================================
	// Checks
	// ==========================================================
	a_init_req_sid: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(rng_q == RS_SEARCH && sync_ok && i_init_maint)
		|=> o_rng_req && o_rng_sid == SID_UNINIT)
		else $error("initial request without zero identifier");
	a_no_early_req: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(rng_q == RS_SEARCH && !i_init_maint) |=> !o_rng_req)
		else $error("ranging request outside initial maintenance");
	a_offset_init: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(rng_q == RS_SEARCH) |-> toff_q == FIXED_DELAY)
		else $error("timing offset not at fixed delay before ranging");
	a_sta_wait: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(rng_q == RS_WSTA && sync_ok && i_sta_maint)
		|=> o_rng_req && o_rng_sid == $past(sid_q))
		else $error("station request missing or wrong identifier");
	a_slot_align: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_slot_start |-> (ts_q & ts_mask) == 32'h0000_0000)
		else $error("slot start off a slot boundary");
	a_lost_stop: assert property (@(posedge i_clk) disable iff (!i_resetn)
		rs_q |=> !o_up_enable ##1 !o_ranged)
		else $error("upstream still enabled after lost timing");

endmodule : urb_top

// ### tb/urb_headend.sv
// Head-end model: answers ranging requests and contention transmissions.
// Assumes the block's request pulses arrive on the shared clock.
`timescale 1ns/1ps
module urb_headend (
	// Clock
	input  wire logic        i_clk,
	// Block side
	input  wire logic        i_rng_req,     // Ranging request sent
	input  wire logic        i_cont_tx,     // Contention transmission
	input  wire logic [1:0]  i_mode,        // 0 ack, 1 lose, 2 silent
	// Answers
	output logic             o_rsp_valid,   // Ranging response pulse
	output logic [13:0]      o_rsp_sid,     // Temporary identifier
	output logic [31:0]      o_rsp_toff,    // Timing correction
	output logic             o_rsp_success, // Ranging finished
	output logic             o_rsp_abort,   // Ranging abandoned
	output logic             o_ack,         // Grant or acknowledge
	output logic             o_map_late     // Map without acknowledge
);
	int n_req = 0; // Requests answered so far
	initial begin
		o_rsp_valid   = 1'b0;
		o_rsp_sid     = 14'h3fff;
		o_rsp_toff    = 32'hffff_ffff;
		o_rsp_success = 1'b0;
		o_rsp_abort   = 1'b0;
		o_ack         = 1'b0;
		o_map_late    = 1'b0;
	end
	// ==========================================================
	// Ranging replies
	// ==========================================================
	// Reply three cycles on; second reply succeeds, later ones abort
	always @(posedge i_clk) begin
		if (i_rng_req) begin
			repeat (3) @(posedge i_clk);
			n_req++;
			o_rsp_sid     <= 14'h0123;
			o_rsp_toff    <= 32'h0000_0010;
			o_rsp_success <= (n_req == 2);
			o_rsp_abort   <= (n_req >= 3);
			o_rsp_valid   <= 1'b1;
			@(posedge i_clk);
			// Fields are no longer valid, so show a changed value
			o_rsp_valid   <= 1'b0;
			o_rsp_sid     <= 14'h3edc;
			o_rsp_toff    <= 32'hffff_ffef;
		end
	end
	// ==========================================================
	// Contention verdict, carried by the next map
	// ==========================================================
	always @(posedge i_clk) begin
		if (i_cont_tx && i_mode != 2'h2) begin
			repeat (3) @(posedge i_clk);
			o_ack      <= (i_mode == 2'h0);
			o_map_late <= (i_mode == 2'h1);
			@(posedge i_clk);
			o_ack      <= 1'b0;
			o_map_late <= 1'b0;
		end
	end
endmodule : urb_headend

// ### tb/tb_urb_top.sv
// Testbench for the upstream ranging and back-off block.
// Assumes the head-end model above; map events are driven here.
`timescale 1ns/1ps
module tb_urb_top;
	import urb_pkg::*;
	localparam logic [31:0] FD = 32'h0000_0100; // Fixed internal delay
	logic i_clk = 1'b0, i_resetn = 1'b0, i_ds_sync = 1'b0;
	logic i_ucd_valid = 1'b0, i_sync_msg = 1'b0, i_pdu_ready = 1'b0;
	logic [31:0] i_sync_ts = 32'h0;
	logic [2:0] i_ucd_m = 3'h2;
	logic i_init_maint = 1'b0, i_sta_maint = 1'b0, i_cont_opp = 1'b0;
	logic i_dedicated = 1'b0, i_map_lost = 1'b0;
	logic [3:0] i_bo_start = 4'h0, i_bo_end = 4'h0;
	logic [1:0] mode = 2'h0;
	logic i_rsp_valid, i_rsp_success, i_rsp_abort, i_ack, i_map_late;
	logic [13:0] i_rsp_sid, o_rng_sid, last_sid;
	logic [31:0] i_rsp_toff, o_timing_off, o_timestamp, o_minislot;
	logic o_rng_req, o_ranged, o_up_enable, o_resync, o_slot_start;
	logic o_cont_tx, o_cont_done, o_cont_discard;
	int fail_count = 0, comparisons = 0, cycles = 0;
	int rng_cnt = 0, tx_cnt = 0, done_cnt = 0, disc_cnt = 0, ss_cnt = 0;
	always #2.5 i_clk = ~i_clk;
	urb_top #(.LOST_CYCLES(2000), .FIXED_DELAY(FD)) urb_top_i (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_ds_sync(i_ds_sync),
		.i_ucd_valid(i_ucd_valid), .i_sync_msg(i_sync_msg),
		.i_sync_ts(i_sync_ts), .i_ucd_m(i_ucd_m),
		.i_init_maint(i_init_maint), .i_sta_maint(i_sta_maint),
		.i_bo_start(i_bo_start), .i_bo_end(i_bo_end),
		.i_cont_opp(i_cont_opp), .i_dedicated(i_dedicated), .i_ack(i_ack),
		.i_map_late(i_map_late), .i_map_lost(i_map_lost),
		.i_rsp_valid(i_rsp_valid), .i_rsp_sid(i_rsp_sid),
		.i_rsp_toff(i_rsp_toff), .i_rsp_success(i_rsp_success),
		.i_rsp_abort(i_rsp_abort), .i_pdu_ready(i_pdu_ready),
		.i_seed_ld(1'b0),
		.i_seed(16'h5a3c), .o_rng_req(o_rng_req), .o_rng_sid(o_rng_sid),
		.o_timing_off(o_timing_off), .o_ranged(o_ranged),
		.o_up_enable(o_up_enable), .o_resync(o_resync),
		.o_timestamp(o_timestamp), .o_minislot(o_minislot),
		.o_slot_start(o_slot_start), .o_cont_tx(o_cont_tx),
		.o_cont_done(o_cont_done), .o_cont_discard(o_cont_discard));
	urb_headend urb_headend_i (.i_clk(i_clk), .i_rng_req(o_rng_req),
		.i_cont_tx(o_cont_tx), .i_mode(mode), .o_rsp_valid(i_rsp_valid),
		.o_rsp_sid(i_rsp_sid), .o_rsp_toff(i_rsp_toff),
		.o_rsp_success(i_rsp_success), .o_rsp_abort(i_rsp_abort),
		.o_ack(i_ack),
		.o_map_late(i_map_late));
	// ==========================================================
	// Pulse counters; one-cycle outputs are caught mid-cycle,
	// so no count races a check made at a rising edge
	// ==========================================================
	always @(negedge i_clk) begin
		cycles++;
		if (o_rng_req) begin
			rng_cnt++;
			last_sid = o_rng_sid;
		end
		if (o_cont_tx) tx_cnt++;
		if (o_cont_done) done_cnt++;
		if (o_cont_discard) disc_cnt++;
		if (o_slot_start) ss_cnt++;
		// A hang is cut short well past the planned run length
		if (cycles == 10000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One-cycle map event: 0 init, 1 station, 2 opp, 3 lost, 4 dedicated
	task automatic pulse(input int sel);
		@(posedge i_clk);
		i_init_maint <= (sel == 0);
		i_sta_maint  <= (sel == 1);
		i_cont_opp   <= (sel == 2);
		i_map_lost   <= (sel == 3);
		i_dedicated  <= (sel == 4);
		@(posedge i_clk);
		{i_init_maint, i_sta_maint, i_cont_opp, i_map_lost} <= 4'h0;
		i_dedicated <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask : pulse
	// Data arrives, then opportunities are offered one at a time
	task automatic contend(input logic [1:0] md, input int n);
		@(posedge i_clk);
		mode <= md;
		i_pdu_ready <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_pdu_ready <= 1'b0;
		repeat (n) pulse(2);
	endtask : contend
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (8) @(posedge i_clk);
		i_resetn  <= 1'b1;
		i_ds_sync <= 1'b1;
		@(posedge i_clk);
		i_sync_ts  <= 32'h0000_12ff;
		i_sync_msg <= 1'b1;
		@(posedge i_clk);
		i_sync_msg <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		check("offset", FD, o_timing_off);
		check("minislot", 32'h0000_0012, o_minislot);
		check("timestamp", 32'h0000_12ff, o_timestamp);
		pulse(0);
		check("early request", 0, rng_cnt);
		i_ucd_valid <= 1'b1;
		repeat (3) @(posedge i_clk);
		pulse(0);
		check("first request", 1, rng_cnt);
		check("first sid", 14'h0000, last_sid);
		check("temp sid", 14'h0123, o_rng_sid);
		check("offset corr", FD + 32'h10, o_timing_off);
		pulse(1);
		check("second sid", 14'h0123, last_sid);
		repeat (6) @(posedge i_clk);
		#1;
		check("ranged", 1'b1, o_ranged);
		check("upstream on", 1'b1, o_up_enable);
		contend(2'h1, 15);
		check("no discard", 0, disc_cnt);
		pulse(2);
		check("tx count", 16, tx_cnt);
		check("discard", 1, disc_cnt);
		contend(2'h0, 1);
		check("acked", 1, done_cnt);
		contend(2'h2, 1);
		pulse(3);
		check("lost map", 2, done_cnt);
		i_bo_start <= 4'h4;
		i_bo_end   <= 4'h4;
		contend(2'h0, 0);
		pulse(4);
		check("dedicated", 3, done_cnt);
		check("dedicated tx", 18, tx_cnt);
		repeat (2100) @(posedge i_clk);
		#1;
		check("resync", 1'b1, o_resync);
		check("upstream off", 1'b0, o_up_enable);
		// Edge 10 loaded the timestamp; one step per tick since then
		check("tick", 32'h0000_12ff + 32'((cycles - 9) / TICK_CYCLES),
			o_timestamp);
		check("slot number", 32'h0000_0013, o_minislot);
		check("slot starts", 1, ss_cnt);
		// Timing returns; the head-end aborts the fresh ranging attempt
		@(posedge i_clk);
		i_sync_msg <= 1'b1;
		@(posedge i_clk);
		i_sync_msg <= 1'b0;
		pulse(0);
		check("resync cleared", 1'b0, o_resync);
		check("third request", 3, rng_cnt);
		check("aborted", 1'b0, o_up_enable);
		complete_run();
	end
endmodule : tb_urb_top
